// File: hw/rtc_bcd_counter.sv
`timescale 1ns/10ps
`include "rtc_regs.svh"
module rtc_bcd_counter #(
	parameter logic [7:0] MIN_VAL = `RTC_BCD_ZERO, // First value in packed BCD
	parameter logic [7:0] MAX_VAL = `RTC_SEC_MAX // Last value in packed BCD
) (
	input wire logic clock, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic inc, // Advance by one
	input wire logic load, // Take load_value
	input wire rtc_pkg::rtc_byte_t load_value, // Value from transfer register
	output rtc_pkg::rtc_byte_t value, // Present count
	output logic carry // Wrap pulse to next unit
);
	import rtc_pkg::*;

	// Add one to a packed BCD pair
	function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
		rtc_byte_t r;
		r = v;
		if (v[3:0] >= 4'h9) begin
			r[3:0] = 4'h0;
			r[7:4] = v[7:4] + 4'h1;
		end else begin
			r[3:0] = v[3:0] + 4'h1;
		end
		return r;
	endfunction

	rtc_byte_t next_value; // Value after one step

	// Wrap to the minimum after the maximum [R15]
	always_comb begin
		next_value = (value == MAX_VAL) ? MIN_VAL : bcd_inc(value);
	end

	// Carry leaves in the same cycle as the wrap
	assign carry = inc && (value == MAX_VAL); // [R15]

	// Load from the host has priority over counting
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			value <= MIN_VAL;
		end else if (load) begin
			value <= load_value; // [R14]
		end else if (inc) begin
			value <= next_value;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_wrap_min: assert property (inc && !load && value == MAX_VAL |=> value == MIN_VAL) // [R15]
		else $error("Counter did not wrap to its minimum");
	a_idle_stable: assert property (!inc && !load |=> $stable(value)) // [R16]
		else $error("Counter moved without a step");
endmodule

// File: hw/rtc_div_if.sv
`timescale 1ns/10ps
// Link between access control and the oscillator divider
interface rtc_div_if;
	logic osc_edge; // Synchronised oscillator rising edge
	logic restart; // Hold divider at zero
	logic hold; // Freeze divider while oscillator stopped
	logic tick; // One hundredth step, one-cycle pulse
	modport prescaler (input osc_edge, input restart, input hold, output tick);
	modport ctrl (output osc_edge, output restart, output hold, input tick);
endinterface

// File: hw/rtc_pkg.sv
package rtc_pkg;
	// One register byte
	typedef logic [7:0] rtc_byte_t;
	// Register pointer of the serial engine
	typedef logic [3:0] rtc_ptr_t;
	// Clock-output frequency select code
	typedef logic [3:0] rtc_fsel_t;
	// Access state of the transfer registers
	typedef enum logic [2:0] {
		RTC_ST_IDLE = 3'b001,
		RTC_ST_HOLD = 3'b010,
		RTC_ST_DIRTY = 3'b100
	} rtc_acc_st_t;
endpackage

// File: hw/rtc_prescaler.sv
`timescale 1ns/10ps
`include "rtc_regs.svh"
module rtc_prescaler #(
	parameter int DIV = `RTC_OSC_DIV // Oscillator edges per step
) (
	input wire logic clock, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	rtc_div_if.prescaler div // Divider control and tick
);
	import rtc_pkg::*;

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count; // Edges seen in this step

	// Divider count; restart wins over everything so a write restarts cleanly
	always_ff @(posedge clock) begin
		if (!rst_b || div.restart) begin
			count <= '0;
		end else if (div.hold) begin
			count <= count; // Stopped oscillator freezes the chain [R16]
		end else if (div.osc_edge) begin
			count <= (count == LAST) ? '0 : count + 1'b1; // [R01]
		end
	end

	// Step pulse on the edge that wraps the count
	always_ff @(posedge clock) begin
		if (!rst_b || div.restart) begin
			div.tick <= 1'b0;
		end else begin
			div.tick <= !div.hold && div.osc_edge && (count == LAST); // [R01]
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_tick_period: assert property (div.tick |-> $past(count) == LAST) // [R01]
		else $error("Step pulse without full divide count");
	a_restart_zero: assert property (div.restart |=> count == '0 && !div.tick) // [R02]
		else $error("Divider not cleared by restart");
	a_hold_frozen: assert property (div.hold && !div.restart |=> $stable(count) && !div.tick) // [R16]
		else $error("Divider moved while oscillator stopped");
endmodule

// File: hw/rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register addresses of the clock section
`define RTC_ADDR_SUBSEC 4'h0
`define RTC_ADDR_SEC 4'h1
`define RTC_ADDR_MIN 4'h2
`define RTC_ADDR_HOUR 4'h3
`define RTC_ADDR_WDAY 4'h4
`define RTC_ADDR_CLOCK_LAST 4'h7
`define RTC_NUM_REGS 5

// Oscillator edges per hundredth step
`define RTC_OSC_DIV 328

// Field positions
`define RTC_BIT_OSC_STOP 7
`define RTC_BIT_FAIL_IE 7
`define RTC_FSEL_MSB 7
`define RTC_FSEL_LSB 4

// Field masks of implemented counter and register bits
`define RTC_MASK_SUBSEC 8'hFF
`define RTC_MASK_FULL 8'hFF
`define RTC_MASK_SEC 8'h7F
`define RTC_MASK_MIN 8'h7F
`define RTC_MASK_HOUR 8'h3F
`define RTC_MASK_WDAY 8'h07
`define RTC_MASK_WDAY_REG 8'hF7

// Counter ranges in packed BCD
`define RTC_SUBSEC_ZERO 8'h00
`define RTC_SUBSEC_MAX 8'h99
`define RTC_SEC_MAX 8'h59
`define RTC_MIN_MAX 8'h59
`define RTC_HOUR_MAX 8'h23
`define RTC_WDAY_MIN 8'h01
`define RTC_WDAY_MAX 8'h07
`define RTC_BCD_ZERO 8'h00

// Reset values of control fields
`define RTC_RST_OSC_STOP 1'h0
`define RTC_RST_FAIL_IE 1'h0
`define RTC_RST_FSEL 4'h0

`endif

// File: hw/rtc_time_counters.sv
`timescale 1ns/10ps
`include "rtc_regs.svh"
// Contract
// R01 - Hundredths step every 328 oscillator cycles
// R02 - Clock write restarts divider, zeroes sub-seconds
// R03 - Host writes only zero to sub-seconds
// R04 - Sub-seconds: tenths high nibble, hundredths low
// R05 - Seconds bit 7 stops the oscillator
// R06 - Seconds bits 6..0 count BCD 0..59
// R07 - Minutes bit 7 enables oscillator-fail interrupt
// R08 - Minutes bits 6..0 count BCD 0..59
// R09 - Hours bits 5..0 count BCD 0..23
// R10 - Host writes zero to unused bits
// R11 - Weekday bits 7..4 select clock output
// R12 - Weekday bits 2..0 cycle 1..7
// R13 - Access start freezes transfer registers
// R14 - Written bytes commit at pointer 08h or STOP
// R15 - Counters wrap and carry to next unit
// R16 - Stop bit freezes divider and counters
module rtc_time_counters #(
	parameter int OSC_DIV = `RTC_OSC_DIV // Oscillator edges per hundredth
) (
	input wire logic clock, // 250 MHz system clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic osc_clk_pin, // 32.768 kHz oscillator, asynchronous
	input wire logic osc_fail_pin, // Oscillator failure detector, asynchronous
	input wire logic i2c_start, // Serial access begins, pulse
	input wire logic i2c_stop, // STOP condition seen, pulse
	input wire logic ptr_load, // Load register pointer, pulse
	input wire rtc_pkg::rtc_ptr_t ptr_value, // New pointer value
	input wire logic wr_valid, // Data byte written at pointer, pulse
	input wire rtc_pkg::rtc_byte_t wr_data, // Written byte
	input wire logic rd_ack, // Read byte taken by engine, pulse
	output rtc_pkg::rtc_byte_t rd_data, // Byte at pointer, registered
	output logic oscillator_stop, // Oscillator disabled
	output logic oscillator_fail_irq, // Oscillator fail interrupt
	output rtc_pkg::rtc_fsel_t clock_output_freq_select // Clock-output frequency code
);
	import rtc_pkg::*;

	// Implemented-bit mask of each register as seen by the host
	function automatic rtc_byte_t reg_mask(input int idx);
		case (idx)
			0: reg_mask = `RTC_MASK_SUBSEC;
			1: reg_mask = `RTC_MASK_FULL;
			2: reg_mask = `RTC_MASK_FULL;
			3: reg_mask = `RTC_MASK_HOUR;
			4: reg_mask = `RTC_MASK_WDAY_REG;
			default: reg_mask = 8'h00;
		endcase
	endfunction

	// Counter field mask of each register
	function automatic rtc_byte_t cnt_mask(input int idx);
		case (idx)
			0: cnt_mask = `RTC_MASK_SUBSEC;
			1: cnt_mask = `RTC_MASK_SEC;
			2: cnt_mask = `RTC_MASK_MIN;
			3: cnt_mask = `RTC_MASK_HOUR;
			4: cnt_mask = `RTC_MASK_WDAY;
			default: cnt_mask = 8'h00;
		endcase
	endfunction

	// Pointer falls in the clock section
	function automatic logic is_clock_addr(input rtc_ptr_t p);
		is_clock_addr = (p <= `RTC_ADDR_CLOCK_LAST);
	endfunction

	// Asynchronous pin synchronisers
	logic osc_meta; // First stage, read only by osc_sync
	logic osc_sync; // Second stage
	logic osc_prev; // Delayed copy for edge detection
	logic fail_meta; // First stage, read only by fail_sync
	logic fail_sync; // Second stage

	// Access and transfer state
	rtc_acc_st_t st; // Access state
	rtc_acc_st_t next_st; // Next access state
	rtc_ptr_t ptr; // Register pointer
	rtc_byte_t xfer [0:`RTC_NUM_REGS-1]; // Host-visible transfer registers
	rtc_byte_t live [0:`RTC_NUM_REGS-1]; // Counters with control bits merged
	rtc_byte_t load_val [0:`RTC_NUM_REGS-1]; // Counter load values
	rtc_byte_t cnt_value [0:`RTC_NUM_REGS-1]; // Counter outputs
	logic [`RTC_NUM_REGS:0] step; // Step into each counter
	logic advance; // Pointer moves after a byte
	logic clock_write; // Byte written into the clock section
	logic pending; // Clock section holds uncommitted bytes
	logic commit_now; // Commit decided this cycle
	logic commit_q; // Commit carried out this cycle
	logic frozen; // Transfer registers not refreshed
	logic fail_ie; // Oscillator fail interrupt enable

	rtc_div_if div (); // Divider link

	// Two flip-flops before the oscillator edge is looked at
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
		end else begin
			osc_meta <= osc_clk_pin;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
		end
	end

	// Failure detector level crosses into the clock domain
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			fail_meta <= 1'b0;
			fail_sync <= 1'b0;
		end else begin
			fail_meta <= osc_fail_pin;
			fail_sync <= fail_meta;
		end
	end

	// Divider control: any pending clock write keeps the chain at zero
	assign div.osc_edge = osc_sync && !osc_prev;
	assign div.restart = (st == RTC_ST_DIRTY) || commit_q; // [R02]
	assign div.hold = oscillator_stop; // [R05] [R16]

	rtc_prescaler #(
		.DIV(OSC_DIV)
	) u_prescaler (
		.clock(clock),
		.rst_b(rst_b),
		.div(div)
	);

	// Byte traffic from the serial engine
	assign advance = wr_valid || rd_ack;
	assign clock_write = wr_valid && is_clock_addr(ptr); // [R02]
	assign pending = (st == RTC_ST_DIRTY) || clock_write;
	// Commit on STOP, or when the pointer steps from the last clock address
	assign commit_now = pending && (i2c_stop || (advance && ptr == `RTC_ADDR_CLOCK_LAST)); // [R14]
	// A frozen image stays while the pointer sits on clock addresses
	assign frozen = (st == RTC_ST_DIRTY) || ((st == RTC_ST_HOLD) && is_clock_addr(ptr)); // [R13]

	// Access state: idle refreshes, hold freezes, dirty waits for commit
	always_comb begin
		next_st = st;
		case (st)
			RTC_ST_IDLE: begin
				if (i2c_start) begin
					next_st = RTC_ST_HOLD; // [R13]
				end
			end
			RTC_ST_HOLD: begin
				if (i2c_stop) begin
					next_st = RTC_ST_IDLE;
				end else if (clock_write && !commit_now) begin
					next_st = RTC_ST_DIRTY;
				end
			end
			RTC_ST_DIRTY: begin
				if (i2c_stop) begin
					next_st = RTC_ST_IDLE; // [R14]
				end else if (commit_now) begin
					next_st = RTC_ST_HOLD; // [R14]
				end
			end
			default: next_st = RTC_ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st <= RTC_ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Commit lags the decision by one cycle so a byte written with it has landed
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			commit_q <= 1'b0;
		end else begin
			commit_q <= commit_now;
		end
	end

	// Register pointer, wraps over the sixteen addresses
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ptr <= `RTC_ADDR_SUBSEC;
		end else if (ptr_load) begin
			ptr <= ptr_value;
		end else if (advance) begin
			ptr <= ptr + 4'h1;
		end
	end

	// Live image: counters with control fields folded in
	always_comb begin
		for (int i = 0; i < `RTC_NUM_REGS; i++) begin
			live[i] = cnt_value[i] & cnt_mask(i);
		end
		live[1][`RTC_BIT_OSC_STOP] = oscillator_stop; // [R05]
		live[2][`RTC_BIT_FAIL_IE] = fail_ie; // [R07]
		live[4][`RTC_FSEL_MSB:`RTC_FSEL_LSB] = clock_output_freq_select; // [R11]
	end

	// Transfer registers: written bytes, else refresh unless frozen
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int i = 0; i < `RTC_NUM_REGS; i++) begin
				xfer[i] <= `RTC_BCD_ZERO;
			end
		end else begin
			for (int i = 0; i < `RTC_NUM_REGS; i++) begin
				if (wr_valid && ptr == 4'(i)) begin
					// Unused bits read as zero; a byte written to sub-seconds is stored as zero
					xfer[i] <= (i == 0) ? `RTC_SUBSEC_ZERO : (wr_data & reg_mask(i)); // [R03] [R10]
				end else if (!frozen) begin
					xfer[i] <= live[i]; // [R13]
				end
			end
		end
	end

	// Load values: sub-seconds are forced to zero on every commit
	always_comb begin
		for (int i = 0; i < `RTC_NUM_REGS; i++) begin
			load_val[i] = xfer[i] & cnt_mask(i);
		end
		load_val[0] = `RTC_SUBSEC_ZERO; // [R02]
	end

	// Counter chain: hundredths, seconds, minutes, hours, weekday
	assign step[0] = div.tick && !oscillator_stop; // [R01] [R16]
	generate
		for (genvar g = 0; g < `RTC_NUM_REGS; g++) begin : g_cnt
			localparam logic [7:0] CMIN = (g == 4) ? `RTC_WDAY_MIN : `RTC_BCD_ZERO;
			localparam logic [7:0] CMAX = (g == 0) ? `RTC_SUBSEC_MAX : (g == 1) ? `RTC_SEC_MAX :
				(g == 2) ? `RTC_MIN_MAX : (g == 3) ? `RTC_HOUR_MAX : `RTC_WDAY_MAX;
			// Tenths above hundredths in one pair; the others as listed [R04] [R06] [R08] [R09] [R12]
			rtc_bcd_counter #(
				.MIN_VAL(CMIN),
				.MAX_VAL(CMAX)
			) u_cnt (
				.clock(clock),
				.rst_b(rst_b),
				.inc(step[g] && !commit_q),
				.load(commit_q), // [R14]
				.load_value(load_val[g]),
				.value(cnt_value[g]),
				.carry(step[g+1]) // [R15]
			);
		end
	endgenerate

	// Control fields take effect with the commit, like the counters
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			oscillator_stop <= `RTC_RST_OSC_STOP;
			fail_ie <= `RTC_RST_FAIL_IE;
			clock_output_freq_select <= `RTC_RST_FSEL;
		end else if (commit_q) begin
			oscillator_stop <= xfer[1][`RTC_BIT_OSC_STOP]; // [R05]
			fail_ie <= xfer[2][`RTC_BIT_FAIL_IE]; // [R07]
			clock_output_freq_select <= xfer[4][`RTC_FSEL_MSB:`RTC_FSEL_LSB]; // [R11]
		end
	end

	// Failure interrupt only when enabled; code 0000 means no clock output downstream
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			oscillator_fail_irq <= 1'b0;
		end else begin
			oscillator_fail_irq <= fail_ie && fail_sync; // [R07]
		end
	end

	// Read data: transfer byte at the pointer, other addresses read zero here
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rd_data <= `RTC_BCD_ZERO;
		end else if (ptr < 4'(`RTC_NUM_REGS)) begin
			rd_data <= xfer[ptr[2:0]];
		end else begin
			rd_data <= `RTC_BCD_ZERO;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// A clock write with no commit decided in the same cycle
	sequence s_clock_write;
		clock_write && !commit_now;
	endsequence
	sequence s_commit_load;
		commit_q ##1 (cnt_value[0] == `RTC_SUBSEC_ZERO);
	endsequence

	a_write_restart: assert property (s_clock_write |=> div.restart) // [R02]
		else $error("Clock write did not restart the divider");
	a_commit_zero: assert property (commit_now |=> s_commit_load) // [R02]
		else $error("Commit did not zero the sub-seconds");
	a_commit_sec: assert property (commit_q |=> cnt_value[1] == $past(xfer[1] & `RTC_MASK_SEC)) // [R06] [R14]
		else $error("Seconds not taken from transfer register");
	a_stop_commit: assert property (i2c_stop && pending |=> commit_q) // [R14]
		else $error("STOP did not commit pending bytes");
	a_freeze_hold: assert property (frozen && !wr_valid |=> $stable(xfer[2]) && $stable(xfer[3])) // [R13]
		else $error("Transfer image changed during access");
	a_stop_freeze: assert property (oscillator_stop && !commit_q |=> $stable(cnt_value[0]) [*2]) // [R16]
		else $error("Counters moved with oscillator stopped");
	a_irq_gate: assert property (!fail_ie |=> !oscillator_fail_irq) // [R07]
		else $error("Failure interrupt raised while disabled");
	a_unused_zero: assert property (wr_valid && ptr == `RTC_ADDR_HOUR |=> xfer[3][7:6] == 2'h0) // [R10]
		else $error("Unused hour bits stored");
	a_wday_range: assert property (step[4] && !commit_q |=> cnt_value[4] >= `RTC_WDAY_MIN && cnt_value[4] <= `RTC_WDAY_MAX) // [R12]
		else $error("Weekday left the range one to seven");
	a_hour_wrap: assert property (step[3] && !commit_q && cnt_value[3] == `RTC_HOUR_MAX |=> // [R15]
		cnt_value[3] == `RTC_BCD_ZERO && cnt_value[4] != $past(cnt_value[4]))
		else $error("Hours wrap did not reach zero and step the weekday");
endmodule

// File: verification/rtc_host_model.sv
`timescale 1ns/10ps
// Stand-in for the serial engine: issues one access strobe at a time, except STOP together with a last byte
module rtc_host_model (
	input wire logic clock, // System clock
	input wire rtc_pkg::rtc_byte_t rd_data, // Byte at pointer
	output logic i2c_start, // Access begins
	output logic i2c_stop, // STOP condition
	output logic ptr_load, // Pointer load strobe
	output rtc_pkg::rtc_ptr_t ptr_value, // Pointer value
	output logic wr_valid, // Write strobe
	output rtc_pkg::rtc_byte_t wr_data, // Written byte
	output logic rd_ack // Read taken strobe
);
	import rtc_pkg::*;

	// Idle levels at time zero
	initial begin
		i2c_start = 1'b0;
		i2c_stop = 1'b0;
		ptr_load = 1'b0;
		ptr_value = 4'h0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_ack = 1'b0;
	end

	// START; freezes the transfer bytes for the access
	task automatic open_access();
		@(posedge clock);
		i2c_start <= 1'b1;
		@(posedge clock);
		i2c_start <= 1'b0;
	endtask

	// Pointer load; released lines show the inverse so stale values never pass
	task automatic point(input rtc_ptr_t p);
		@(posedge clock);
		ptr_load <= 1'b1;
		ptr_value <= p;
		@(posedge clock);
		ptr_load <= 1'b0;
		ptr_value <= ~p;
	endtask

	// One written byte; data is passed raw so refused patterns can be tried
	// A last byte may carry STOP in the same cycle
	task automatic put(input rtc_byte_t b, input logic last = 1'b0);
		@(posedge clock);
		wr_valid <= 1'b1;
		wr_data <= b;
		i2c_stop <= last;
		@(posedge clock);
		wr_valid <= 1'b0;
		wr_data <= ~b;
		i2c_stop <= 1'b0;
	endtask

	// One read byte; sampled mid-cycle once rd_data follows the pointer
	task automatic get(output rtc_byte_t b);
		@(posedge clock);
		@(negedge clock);
		b = rd_data;
		@(posedge clock);
		rd_ack <= 1'b1;
		@(posedge clock);
		rd_ack <= 1'b0;
	endtask

	// STOP; commits written clock bytes and resumes refresh
	task automatic close_access();
		@(posedge clock);
		i2c_stop <= 1'b1;
		@(posedge clock);
		i2c_stop <= 1'b0;
	endtask
endmodule

// File: verification/rtc_time_counters_tb.sv
`timescale 1ns/10ps
`define CHK(what, e, g) check_val(what, e, g)
// Bench for the low time counters, with a shortened divider
module rtc_time_counters_tb;
	import rtc_pkg::*;
	localparam int DIV = 4; // Short divider keeps rollovers cheap
	localparam int TIMEOUT = 20000; // Whole run needs about 5000 cycles
	// One register row: address, byte written, byte read back
	typedef struct {rtc_ptr_t a; rtc_byte_t w; rtc_byte_t e;} rtc_row_t;
	logic clock = 1'b0; // System clock
	logic rst_b = 1'b0; // Reset, active low
	logic osc_clk_pin = 1'b0; // Oscillator, ten clocks a period
	logic osc_fail_pin = 1'b0; // Failure detector level
	logic i2c_start, i2c_stop, ptr_load, wr_valid, rd_ack; // Host strobes
	rtc_ptr_t ptr_value; // Host pointer
	rtc_byte_t wr_data, rd_data; // Data both ways
	logic oscillator_stop, oscillator_fail_irq; // Control outputs
	rtc_fsel_t clock_output_freq_select; // Output code
	int fail_count = 0; // Mismatches
	int n_compared = 0; // Comparisons
	int cyc = 0; // Cycle count for timeout and oscillator
	rtc_byte_t b; // Scratch read byte
	rtc_byte_t got [0:7]; // Burst read result
	rtc_byte_t rst_exp [0:5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	rtc_byte_t roll_exp [0:4] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h51};
	rtc_byte_t burst [0:6] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	rtc_row_t rows [0:7] = '{
		'{4'h1, 8'hD9, 8'hD9},
		'{4'h2, 8'h59, 8'h59},
		'{4'h3, 8'h23, 8'h23},
		'{4'h4, 8'h57, 8'h57},
		'{4'h0, 8'h45, 8'h00},
		'{4'h3, 8'hE3, 8'h23},
		'{4'h4, 8'h5F, 8'h57},
		'{4'h2, 8'hD9, 8'hD9}
	};

	rtc_time_counters #(.OSC_DIV(DIV)) u_dut (
		.clock(clock), .rst_b(rst_b), .osc_clk_pin(osc_clk_pin), .osc_fail_pin(osc_fail_pin),
		.i2c_start(i2c_start), .i2c_stop(i2c_stop), .ptr_load(ptr_load), .ptr_value(ptr_value),
		.wr_valid(wr_valid), .wr_data(wr_data), .rd_ack(rd_ack), .rd_data(rd_data),
		.oscillator_stop(oscillator_stop), .oscillator_fail_irq(oscillator_fail_irq),
		.clock_output_freq_select(clock_output_freq_select)
	);

	rtc_host_model u_host (
		.clock(clock), .rd_data(rd_data), .i2c_start(i2c_start), .i2c_stop(i2c_stop),
		.ptr_load(ptr_load), .ptr_value(ptr_value), .wr_valid(wr_valid), .wr_data(wr_data),
		.rd_ack(rd_ack)
	);

	// Clock generator
	always #2 clock = ~clock;

	// Oscillator from the clock so its phase is repeatable; hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc % 5 == 4) begin
			osc_clk_pin <= ~osc_clk_pin;
		end
		if (cyc == TIMEOUT) begin
			fail_count++;
			$display("ERROR timeout expected end seen hang");
			print_verdict();
		end
	end

	// Single comparison; four-state so unknowns fail
	task automatic check_val(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	// Whole write access of one byte, then let the commit land
	task automatic wr1(input rtc_ptr_t p, input rtc_byte_t v);
		u_host.open_access();
		u_host.point(p);
		u_host.put(v);
		u_host.close_access();
		repeat (4) @(posedge clock);
	endtask

	// Whole read access of n bytes into got
	task automatic rd(input rtc_ptr_t p, input int n);
		u_host.open_access();
		u_host.point(p);
		for (int i = 0; i < n; i++) begin
			u_host.get(got[i]);
		end
		u_host.close_access();
	endtask

	// Counts, verdict and end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		`CHK("stop after reset", 8'h00, oscillator_stop);
		rd(4'h0, 6);
		for (int i = 0; i < 6; i++) begin
			`CHK("reset byte", rst_exp[i], got[i]);
		end
		$display("test reset done");
		// Stop bit is written first so later readbacks are exact
		foreach (rows[i]) begin
			wr1(rows[i].a, rows[i].w);
			rd(rows[i].a, 1);
			`CHK("row readback", rows[i].e, got[0]);
		end
		`CHK("stop bit", 8'h01, oscillator_stop);
		`CHK("freq select", 8'h05, clock_output_freq_select);
		`CHK("irq without fail", 8'h00, oscillator_fail_irq);
		@(posedge clock) osc_fail_pin <= 1'b1;
		repeat (6) @(posedge clock);
		`CHK("irq enabled", 8'h01, oscillator_fail_irq);
		wr1(4'h2, 8'h59);
		`CHK("irq disabled", 8'h00, oscillator_fail_irq);
		@(posedge clock) osc_fail_pin <= 1'b0;
		repeat (300) @(posedge clock);
		rd(4'h0, 2);
		`CHK("held subsec", 8'h00, got[0]);
		`CHK("held sec", 8'hD9, got[1]);
		$display("test registers done");
		// Last second of the week; exactly 100 ticks carry every unit
		u_host.open_access();
		u_host.point(4'h1);
		u_host.put(8'h59);
		u_host.put(8'hD9);
		u_host.put(8'h23);
		u_host.put(8'h57);
		u_host.close_access();
		repeat (4020) @(posedge clock);
		`CHK("running", 8'h00, oscillator_stop);
		rd(4'h0, 5);
		for (int i = 0; i < 5; i++) begin
			`CHK("rollover byte", roll_exp[i], got[i]);
		end
		$display("test rollover done");
		// Mid-run write zeroes sub-seconds; access keeps them frozen
		repeat (200) @(posedge clock);
		wr1(4'h3, 8'h12);
		u_host.open_access();
		u_host.point(4'h0);
		u_host.get(b);
		`CHK("subsec after write", 8'h00, b);
		repeat (120) @(posedge clock);
		u_host.point(4'h0);
		u_host.get(b);
		`CHK("frozen subsec", 8'h00, b);
		u_host.close_access();
		rd(4'h3, 1);
		`CHK("hour written", 8'h12, got[0]);
		$display("test restart done");
		// Pointer running past 07h commits before any STOP
		u_host.open_access();
		u_host.point(4'h1);
		foreach (burst[i]) begin
			u_host.put(burst[i]);
		end
		repeat (4) @(posedge clock);
		`CHK("commit at 08h stop", 8'h01, oscillator_stop);
		`CHK("commit at 08h fsel", 8'h00, clock_output_freq_select);
		u_host.close_access();
		$display("test pointer commit done");
		// STOP in the cycle of the only byte still commits it
		u_host.open_access();
		u_host.point(4'h1);
		u_host.put(8'h30, 1'b1);
		repeat (4) @(posedge clock);
		`CHK("commit with stop", 8'h00, oscillator_stop);
		rd(4'h1, 1);
		`CHK("seconds with stop", 8'h30, got[0]);
		$display("test stop with byte done");
		// Reset in mid-run returns every register to its reset value
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		`CHK("fsel after reset", 8'h00, clock_output_freq_select);
		rd(4'h0, 6);
		for (int i = 0; i < 6; i++) begin
			`CHK("mid-run reset byte", rst_exp[i], got[i]);
		end
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
